// *** hdl/dac_link_if.sv ***
/*
 * Pin bundle between the serial master and the converter front end.
 * Assumes all pins are single-direction; the master owns every one but the
 * serial data output.
 */
`timescale 1ns/1ps
interface dac_link_if;
	logic frame_sel_n;
	logic sclk;
	logic serial_in;
	logic serial_out;
	logic load_update_strobe_n;
	logic dac_reset_n;

	modport host (
		output frame_sel_n,
		output sclk,
		output serial_in,
		input  serial_out,
		output load_update_strobe_n,
		output dac_reset_n
	);

	modport device (
		input  frame_sel_n,
		input  sclk,
		input  serial_in,
		output serial_out,
		input  load_update_strobe_n,
		input  dac_reset_n
	);
endinterface : dac_link_if

// *** hdl/dac_link_pkg.sv ***
/*
 * Shared constants for the eight-channel converter serial load path: frame
 * geometry, reset codes and link timing.
 * Assumes a single 50 MHz system clock on both ends of the link.
 */
package dac_link_pkg;
	localparam int          FRAME_BITS    = 24;
	localparam int          CODE_BITS     = 16;
	localparam int          CHANNELS      = 8;
	localparam int          CNT_BITS      = 5;
	localparam int          CHAN_BITS     = 3;
	localparam int          CHAN_LSB      = 16;
	localparam int          CODE_LSB      = 0;
	localparam int          SYNC_STAGES   = 2;
	localparam logic [15:0] ZERO_CODE     = 16'h0000;
	localparam logic [15:0] MID_CODE      = 16'h8000;
	localparam logic [4:0]  FRAME_COUNT   = 5'h18;
	localparam int          CLK_PERIOD_NS = 20;
	localparam int          SCLK_PERIOD_NS = 160;
	localparam int          STROBE_LOW_NS = 80;
	localparam int          SCLK_HALF_CYC = (SCLK_PERIOD_NS / 2) / CLK_PERIOD_NS;
	localparam int          STROBE_CYC    = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          DIV_BITS      = 4;
endpackage : dac_link_pkg

// *** hdl/dac_serial_device.sv ***
/*
 * Converter-side digital front end: samples the link pins on the system
 * clock, shifts in 24-bit frames, keeps eight input and eight DAC code
 * registers and handles the load strobe and the pin reset.
 * Assumes the link clock is at most a quarter of the system clock.
 */
`timescale 1ns/1ps

// Functional notes
// - Frame select low, then 24 falling edges
// - 24-bit shift register samples on falling edge
// - Host keeps serial clock at most 50 MHz
// - Strobe low pulse copies new data together
// - Strobe works pulsed or follows the write
// - Strobe held low updates without pulse
// - Serial out changes on rising edges
// - Pin reset acts on its falling edge
// - Pin reset low blocks all DAC updates
// - Reset loads input and DAC registers
// - Select low zero scale, high midscale
// - Eight channels, 16-bit codes each
module dac_serial_device (
	// System
	input  wire logic                                               ref_clk_i,
	input  wire logic                                               reset_i,
	// Board strap
	input  wire logic                                               reset_level_select_i,
	// Link pins
	dac_link_if.device                                              link,
	// Converter side
	output logic [dac_link_pkg::CHANNELS*dac_link_pkg::CODE_BITS-1:0] dac_codes_o,
	output logic [dac_link_pkg::CHANNELS*dac_link_pkg::CODE_BITS-1:0] input_codes_o,
	output logic [dac_link_pkg::CHANNELS-1:0]                       pending_o,
	output logic                                                    update_o
);
	localparam int PIN_FRAME  = 0;
	localparam int PIN_SCLK   = 1;
	localparam int PIN_SDI    = 2;
	localparam int PIN_STROBE = 3;
	localparam int PIN_RST    = 4;
	localparam int PIN_SEL    = 5;
	localparam int PINS       = 6;

	logic [PINS-1:0]                         meta_reg;
	logic [PINS-1:0]                         sync_reg;
	logic [PINS-1:0]                         prev_reg;
	logic [dac_link_pkg::FRAME_BITS-1:0]     shift_reg;
	logic [dac_link_pkg::FRAME_BITS-1:0]     shift_next;
	logic [dac_link_pkg::CNT_BITS-1:0]       count_reg;
	logic [dac_link_pkg::CNT_BITS-1:0]       count_next;
	logic                                    in_frame_reg;
	logic                                    in_frame_next;
	logic                                    so_reg;
	logic                                    so_next;
	logic [1:0]                              settle_reg;
	logic [1:0]                              settle_next;
	logic [dac_link_pkg::CODE_BITS-1:0]      in_code_reg  [dac_link_pkg::CHANNELS];
	logic [dac_link_pkg::CODE_BITS-1:0]      in_code_next [dac_link_pkg::CHANNELS];
	logic [dac_link_pkg::CODE_BITS-1:0]      dac_code_reg [dac_link_pkg::CHANNELS];
	logic [dac_link_pkg::CODE_BITS-1:0]      dac_code_next[dac_link_pkg::CHANNELS];
	logic [dac_link_pkg::CHANNELS-1:0]       pending_reg;
	logic [dac_link_pkg::CHANNELS-1:0]       pending_next;
	logic                                    update_reg;
	logic                                    update_next;

	logic                                    sclk_fall;
	logic                                    sclk_rise;
	logic                                    frame_start;
	logic                                    frame_end;
	logic                                    word_done;
	logic                                    rst_fall;
	logic                                    rst_low;
	logic                                    strobe_fall;
	logic                                    strobe_low;
	logic [dac_link_pkg::CODE_BITS-1:0]      reset_code;
	logic [dac_link_pkg::CHAN_BITS-1:0]      word_chan;
	logic [dac_link_pkg::CODE_BITS-1:0]      word_code;

	// Two-stage synchronisers for every pin
	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			meta_reg <= 6'h1B;
			sync_reg <= 6'h1B;
			prev_reg <= 6'h1B;
		end
		else
		begin
			meta_reg <= {reset_level_select_i, link.dac_reset_n, link.load_update_strobe_n,
				link.serial_in, link.sclk, link.frame_sel_n};
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	always_comb
	begin
		sclk_fall   = prev_reg[PIN_SCLK] & ~sync_reg[PIN_SCLK];
		sclk_rise   = ~prev_reg[PIN_SCLK] & sync_reg[PIN_SCLK];
		frame_start = prev_reg[PIN_FRAME] & ~sync_reg[PIN_FRAME];
		frame_end   = ~prev_reg[PIN_FRAME] & sync_reg[PIN_FRAME];
		rst_fall    = prev_reg[PIN_RST] & ~sync_reg[PIN_RST];
		rst_low     = ~sync_reg[PIN_RST];
		strobe_fall = prev_reg[PIN_STROBE] & ~sync_reg[PIN_STROBE];
		strobe_low  = ~sync_reg[PIN_STROBE];
		reset_code  = sync_reg[PIN_SEL] ? dac_link_pkg::MID_CODE : dac_link_pkg::ZERO_CODE;
		word_chan   = shift_reg[dac_link_pkg::CHAN_LSB +: dac_link_pkg::CHAN_BITS];
		word_code   = shift_reg[dac_link_pkg::CODE_LSB +: dac_link_pkg::CODE_BITS];
		word_done   = frame_end & in_frame_reg & (count_reg == dac_link_pkg::FRAME_COUNT);
	end

	// Frame shifter and serial output
	always_comb
	begin
		shift_next    = shift_reg;
		count_next    = count_reg;
		in_frame_next = in_frame_reg;
		so_next       = so_reg;
		if (frame_start)
		begin
			in_frame_next = 1'b1;
			count_next    = '0;
		end
		else if (frame_end)
		begin
			in_frame_next = 1'b0;
		end
		else if (in_frame_reg && sclk_fall && count_reg != dac_link_pkg::FRAME_COUNT)
		begin
			shift_next = {shift_reg[dac_link_pkg::FRAME_BITS-2:0], sync_reg[PIN_SDI]};
			count_next = count_reg + 5'h01;
		end
		if (sclk_rise)
		begin
			so_next = shift_reg[dac_link_pkg::FRAME_BITS-1];
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			shift_reg    <= '0;
			count_reg    <= '0;
			in_frame_reg <= 1'b0;
			so_reg       <= 1'b0;
		end
		else
		begin
			shift_reg    <= shift_next;
			count_reg    <= count_next;
			in_frame_reg <= in_frame_next;
			so_reg       <= so_next;
		end
	end

	// Input and DAC code registers
	always_comb
	begin
		in_code_next  = in_code_reg;
		dac_code_next = dac_code_reg;
		pending_next  = pending_reg;
		update_next   = 1'b0;
		settle_next   = settle_reg;
		if (settle_reg != 2'h3)
		begin
			settle_next = settle_reg + 2'h1;
		end
		if (rst_fall || settle_reg == 2'h2)
		begin
			for (int i = 0; i < dac_link_pkg::CHANNELS; i++)
			begin
				in_code_next[i]  = reset_code;
				dac_code_next[i] = reset_code;
			end
			pending_next = '0;
			update_next  = 1'b1;
		end
		else
		begin
			if (strobe_fall && !rst_low)
			begin
				for (int i = 0; i < dac_link_pkg::CHANNELS; i++)
				begin
					if (pending_reg[i])
					begin
						dac_code_next[i] = in_code_reg[i];
					end
				end
				pending_next = '0;
				update_next  = |pending_reg;
			end
			if (word_done)
			begin
				in_code_next[word_chan] = word_code;
				if (strobe_low && !rst_low)
				begin
					dac_code_next[word_chan] = word_code;
					pending_next[word_chan]  = 1'b0;
					update_next              = 1'b1;
				end
				else
				begin
					pending_next[word_chan] = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			for (int i = 0; i < dac_link_pkg::CHANNELS; i++)
			begin
				in_code_reg[i]  <= dac_link_pkg::ZERO_CODE;
				dac_code_reg[i] <= dac_link_pkg::ZERO_CODE;
			end
			pending_reg <= '0;
			update_reg  <= 1'b0;
			settle_reg  <= 2'h0;
		end
		else
		begin
			in_code_reg  <= in_code_next;
			dac_code_reg <= dac_code_next;
			pending_reg  <= pending_next;
			update_reg   <= update_next;
			settle_reg   <= settle_next;
		end
	end

	always_comb
	begin
		for (int i = 0; i < dac_link_pkg::CHANNELS; i++)
		begin
			dac_codes_o[i*dac_link_pkg::CODE_BITS +: dac_link_pkg::CODE_BITS]   = dac_code_reg[i];
			input_codes_o[i*dac_link_pkg::CODE_BITS +: dac_link_pkg::CODE_BITS] = in_code_reg[i];
		end
	end

	assign pending_o       = pending_reg;
	assign update_o        = update_reg;
	assign link.serial_out = so_reg;
endmodule : dac_serial_device

// *** hdl/dac_serial_host.sv ***
/*
 * Serial master for the converter link: makes the link clock by division,
 * sends 24-bit frames, captures the returned serial data and drives the
 * load strobe and the pin reset.
 * Assumes a 50 MHz system clock; the link clock period is 160 ns.
 */
`timescale 1ns/1ps
module dac_serial_host (
	// System
	input  wire logic                                ref_clk_i,
	input  wire logic                                reset_i,
	// Frame request
	input  wire logic                                write_valid_i,
	input  wire logic [dac_link_pkg::FRAME_BITS-1:0] write_word_i,
	output logic                                     write_ready_o,
	// Returned data
	output logic [dac_link_pkg::FRAME_BITS-1:0]      readback_word_o,
	output logic                                     readback_valid_o,
	// Strobe and reset control
	input  wire logic                                load_pulse_i,
	input  wire logic                                load_hold_i,
	input  wire logic                                dac_reset_i,
	// Link pins
	dac_link_if.host                                 link
);
	typedef enum logic [2:0] {ST_IDLE, ST_LEAD, ST_LOW, ST_HIGH, ST_TRAIL} host_state_e;

	localparam logic [3:0] HALF_LAST   = 4'(dac_link_pkg::SCLK_HALF_CYC - 1);
	localparam logic [3:0] STROBE_LAST = 4'(dac_link_pkg::STROBE_CYC);

	host_state_e                         state_reg, state_next;
	logic [dac_link_pkg::DIV_BITS-1:0]   div_reg, div_next;
	logic [dac_link_pkg::CNT_BITS-1:0]   bits_reg, bits_next;
	logic [dac_link_pkg::FRAME_BITS-1:0] tx_reg, tx_next;
	logic [dac_link_pkg::FRAME_BITS-1:0] rx_reg, rx_next;
	logic                                rx_valid_reg, rx_valid_next;
	logic [3:0]                          load_cnt_reg, load_cnt_next;
	logic [3:0]                          rst_cnt_reg, rst_cnt_next;
	logic [1:0]                          so_sync_reg;
	logic                                half_done;

	// Two-stage synchroniser for the returned data
	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			so_sync_reg <= 2'h0;
		end
		else
		begin
			so_sync_reg <= {so_sync_reg[0], link.serial_out};
		end
	end

	always_comb
	begin
		half_done     = (div_reg == HALF_LAST);
		state_next    = state_reg;
		div_next      = half_done ? '0 : div_reg + 4'h1;
		bits_next     = bits_reg;
		tx_next       = tx_reg;
		rx_next       = rx_reg;
		rx_valid_next = 1'b0;
		unique case (state_reg)
			ST_IDLE:
			begin
				div_next = '0;
				if (write_valid_i)
				begin
					tx_next    = write_word_i;
					bits_next  = '0;
					state_next = ST_LEAD;
				end
			end
			ST_LEAD:
				if (half_done)
				begin
					state_next = ST_LOW;
				end
			ST_LOW:
				if (half_done)
				begin
					bits_next  = bits_reg + 5'h01;
					rx_next    = {rx_reg[dac_link_pkg::FRAME_BITS-2:0], so_sync_reg[1]};
					// Next bit leaves on the rising edge so it stands across the following fall
					tx_next    = {tx_reg[dac_link_pkg::FRAME_BITS-2:0], 1'b0};
					state_next = ST_HIGH;
				end
			ST_HIGH:
				if (half_done)
				begin
					if (bits_reg == dac_link_pkg::FRAME_COUNT)
					begin
						state_next = ST_TRAIL;
					end
					else
					begin
						state_next = ST_LOW;
					end
				end
			ST_TRAIL:
				if (half_done)
				begin
					rx_valid_next = 1'b1;
					state_next    = ST_IDLE;
				end
		endcase
		load_cnt_next = load_pulse_i ? STROBE_LAST : (load_cnt_reg != 4'h0 ? load_cnt_reg - 4'h1 : 4'h0);
		rst_cnt_next  = dac_reset_i ? STROBE_LAST : (rst_cnt_reg != 4'h0 ? rst_cnt_reg - 4'h1 : 4'h0);
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			state_reg    <= ST_IDLE;
			div_reg      <= '0;
			bits_reg     <= '0;
			tx_reg       <= '0;
			rx_reg       <= '0;
			rx_valid_reg <= 1'b0;
			load_cnt_reg <= '0;
			rst_cnt_reg  <= '0;
		end
		else
		begin
			state_reg    <= state_next;
			div_reg      <= div_next;
			bits_reg     <= bits_next;
			tx_reg       <= tx_next;
			rx_reg       <= rx_next;
			rx_valid_reg <= rx_valid_next;
			load_cnt_reg <= load_cnt_next;
			rst_cnt_reg  <= rst_cnt_next;
		end
	end

	// Link clock idles high; the device samples on each falling edge
	assign link.frame_sel_n          = (state_reg == ST_IDLE);
	assign link.sclk                 = (state_reg != ST_LOW);
	assign link.serial_in            = tx_reg[dac_link_pkg::FRAME_BITS-1];
	assign link.load_update_strobe_n = ~(load_hold_i | (load_cnt_reg != 4'h0));
	assign link.dac_reset_n          = (rst_cnt_reg == 4'h0);
	assign write_ready_o             = (state_reg == ST_IDLE);
	assign readback_word_o           = rx_reg;
	assign readback_valid_o          = rx_valid_reg;
endmodule : dac_serial_host

// *** tb/dac_link_asserts.sv ***
/*
 * Concurrent checks on the link pins between serial master and converter front end.
 * Assumes it is instantiated beside the link interface, clocked by the host system clock.
 */
`timescale 1ns/1ps
module dac_link_asserts (
	// System
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// Link pins
	input wire logic frame_sel_n,
	input wire logic sclk,
	input wire logic serial_in,
	input wire logic serial_out,
	input wire logic load_update_strobe_n,
	input wire logic dac_reset_n
);
	logic [4:0] falls_reg;
	logic [4:0] falls_next;
	logic       sclk_reg;
	logic       sclk_next;

	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);

	// Counts link clock falls inside the current frame
	always_comb
	begin
		sclk_next  = sclk;
		falls_next = frame_sel_n ? 5'h00 : falls_reg + 5'(sclk_reg & ~sclk);
	end

	always_ff @(posedge ref_clk_i)
	begin
		sclk_reg  <= sclk_next;
		falls_reg <= falls_next;
	end

	a_sclk_idle_high: assert property (frame_sel_n |-> sclk)
		else $error("link clock low outside a frame");
	a_select_leads_clock: assert property ($fell(frame_sel_n) |-> sclk [*4] ##1 !sclk)
		else $error("first clock fall not four cycles after frame start");
	a_low_half_width: assert property ($fell(sclk) |-> !sclk [*4] ##1 sclk)
		else $error("link clock low half not four cycles");
	a_high_half_width: assert property ($rose(sclk) && !frame_sel_n |-> sclk [*4])
		else $error("link clock high half too short");
	a_frame_bit_count: assert property ($rose(frame_sel_n) |-> falls_reg == dac_link_pkg::FRAME_COUNT)
		else $error("frame ended without exactly 24 clock falls");
	a_data_steady_low: assert property (!frame_sel_n && !sclk |-> $stable(serial_in))
		else $error("serial data moved while link clock low");
	a_out_after_rise: assert property ($changed(serial_out) |-> $past(sclk))
		else $error("serial output moved after a falling clock");
	a_strobe_low_width: assert property ($fell(load_update_strobe_n) |-> !load_update_strobe_n [*4])
		else $error("load strobe low shorter than four cycles");
	a_pin_reset_width: assert property ($fell(dac_reset_n) |-> !dac_reset_n [*4] ##1 dac_reset_n)
		else $error("pin reset pulse not four cycles");
endmodule : dac_link_asserts

// *** tb/octal_dac_serial_load_control_test.sv ***
/*
 * Self-checking bench: host and converter joined by one link, plus a second
 * converter whose pins the bench drives to break the framing and reset rules.
 * Assumes the shared package and interface are compiled first.
 */
`timescale 1ns/1ps
module octal_dac_serial_load_control_test;
	logic         ref_clk_i   = 1'b0;
	logic         reset_i     = 1'b1;
	logic         strap       = 1'b1;
	logic         write_valid = 1'b0;
	logic [23:0]  write_word  = 24'h000000;
	logic         load_pulse  = 1'b0;
	logic         load_hold   = 1'b0;
	logic         dac_reset   = 1'b0;
	logic [23:0]  rb_word;
	logic         rb_valid;
	logic         wr_ready;
	logic         upd;
	logic [127:0] dac;
	logic [127:0] inp;
	logic [127:0] dac2;
	logic [127:0] inp2;
	logic [127:0] exp_dac;
	logic [127:0] exp_in;
	logic [7:0]   pend;
	logic [23:0]  mon_word;
	int           mon_cnt;
	int           fail_count;
	int           n_checks;

	dac_link_if lnk();
	dac_link_if lnk2();

	dac_serial_host i_dac_serial_host (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .write_valid_i(write_valid),
		.write_word_i(write_word), .write_ready_o(wr_ready), .readback_word_o(rb_word),
		.readback_valid_o(rb_valid), .load_pulse_i(load_pulse), .load_hold_i(load_hold),
		.dac_reset_i(dac_reset), .link(lnk));
	dac_serial_device i_dac_serial_device (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
		.reset_level_select_i(strap), .link(lnk), .dac_codes_o(dac), .input_codes_o(inp),
		.pending_o(pend), .update_o(upd));
	dac_serial_device i_dac_serial_device_2 (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
		.reset_level_select_i(strap), .link(lnk2), .dac_codes_o(dac2), .input_codes_o(inp2),
		.pending_o(), .update_o());
	dac_link_asserts i_dac_link_asserts (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
		.frame_sel_n(lnk.frame_sel_n), .sclk(lnk.sclk), .serial_in(lnk.serial_in),
		.serial_out(lnk.serial_out), .load_update_strobe_n(lnk.load_update_strobe_n),
		.dac_reset_n(lnk.dac_reset_n));

	always #(dac_link_pkg::CLK_PERIOD_NS / 2) ref_clk_i = ~ref_clk_i;

	// Rebuilds the word seen on the wire at each falling link clock
	always @(negedge lnk.sclk)
	begin
		if (!lnk.frame_sel_n)
		begin
			mon_word = {mon_word[22:0], lnk.serial_in};
			mon_cnt++;
		end
	end

	task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic end_sim;
		$display("checks %0d, mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_sim

	// Waits for ready (0), readback valid (1) or update (2)
	task automatic wait_for(input int sel, input int limit);
		for (int i = 0; i < limit; i++)
		begin
			@(negedge ref_clk_i);
			if ((sel == 0 && wr_ready === 1'b1) || (sel == 1 && rb_valid === 1'b1) || (sel == 2 && upd === 1'b1))
				return;
		end
		fail_count++;
		$display("MISMATCH at %0t: wait %h timed out", $time, sel);
		end_sim();
	endtask : wait_for

	task automatic do_write(input logic [23:0] word);
		wait_for(0, 20);
		mon_cnt = 0;
		write_word = word;
		write_valid = 1'b1;
		@(negedge ref_clk_i);
		write_valid = 1'b0;
		wait_for(1, 400);
		chk(128'(mon_word), 128'(word));
		chk(128'(mon_cnt), 128'(24));
		repeat (6) @(negedge ref_clk_i);
	endtask : do_write

	// Second link is driven by the bench with a 160 ns link clock
	task automatic drv_frame(input logic [23:0] word, input int nbits);
		@(negedge ref_clk_i);
		lnk2.frame_sel_n = 1'b0;
		for (int i = 0; i < nbits; i++)
		begin
			lnk2.serial_in = word[23 - i];
			#80 lnk2.sclk = 1'b0;
			#80 lnk2.sclk = 1'b1;
		end
		#80 lnk2.frame_sel_n = 1'b1;
		lnk2.serial_in = ~lnk2.serial_in;
		repeat (8) @(negedge ref_clk_i);
	endtask : drv_frame

	task automatic strobe_pulse;
		lnk2.load_update_strobe_n = 1'b0;
		repeat (6) @(negedge ref_clk_i);
		lnk2.load_update_strobe_n = 1'b1;
		repeat (6) @(negedge ref_clk_i);
	endtask : strobe_pulse

	task automatic t_power_up;
		exp_in = {8{dac_link_pkg::MID_CODE}};
		exp_dac = exp_in;
		chk(inp, exp_in);
		chk(dac, exp_dac);
		chk(dac2, exp_dac);
		chk(128'(pend), 128'h0);
	endtask : t_power_up

	task automatic t_pulse_load;
		do_write(24'hFBA5C3);
		do_write(24'h170001);
		chk(128'(rb_word), 128'(24'hFBA5C3));
		exp_in[48 +: 16] = 16'hA5C3;
		exp_in[112 +: 16] = 16'h0001;
		chk(inp, exp_in);
		chk(dac, exp_dac);
		chk(128'(pend), 128'h88);
		load_pulse = 1'b1;
		@(negedge ref_clk_i);
		load_pulse = 1'b0;
		wait_for(2, 20);
		exp_dac = exp_in;
		chk(dac, exp_dac);
		chk(128'(pend), 128'h0);
	endtask : t_pulse_load

	task automatic t_hold_load;
		load_hold = 1'b1;
		do_write(24'h301234);
		exp_in[0 +: 16] = 16'h1234;
		chk(dac, exp_in);
		chk(128'(pend), 128'h0);
		load_hold = 1'b0;
	endtask : t_hold_load

	task automatic t_pin_reset;
		strap = 1'b0;
		do_write(24'h35FFFF);
		dac_reset = 1'b1;
		@(negedge ref_clk_i);
		dac_reset = 1'b0;
		repeat (10) @(negedge ref_clk_i);
		exp_in = {8{dac_link_pkg::ZERO_CODE}};
		chk(inp, exp_in);
		chk(dac, exp_in);
		chk(128'(pend), 128'h0);
	endtask : t_pin_reset

	task automatic t_second_end;
		logic [127:0] e2;
		e2 = {8{dac_link_pkg::MID_CODE}};
		lnk2.load_update_strobe_n = 1'b0;
		drv_frame(24'h02BEEF, 23);
		chk(inp2, e2);
		drv_frame(24'h02BEEF, 24);
		e2[32 +: 16] = 16'hBEEF;
		chk(dac2, e2);
		lnk2.load_update_strobe_n = 1'b1;
		lnk2.dac_reset_n = 1'b0;
		repeat (10) @(negedge ref_clk_i);
		e2 = {8{dac_link_pkg::ZERO_CODE}};
		chk(inp2, e2);
		drv_frame(24'h04CAFE, 24);
		e2[64 +: 16] = 16'hCAFE;
		chk(inp2, e2);
		strobe_pulse();
		chk(dac2, {8{dac_link_pkg::ZERO_CODE}});
		lnk2.dac_reset_n = 1'b1;
		repeat (10) @(negedge ref_clk_i);
		strobe_pulse();
		chk(dac2, e2);
	endtask : t_second_end

	initial
	begin
		fail_count = 0;
		n_checks = 0;
		mon_cnt = 0;
		mon_word = 24'h000000;
		lnk2.frame_sel_n = 1'b1;
		lnk2.sclk = 1'b1;
		lnk2.serial_in = 1'b0;
		lnk2.load_update_strobe_n = 1'b1;
		lnk2.dac_reset_n = 1'b1;
		repeat (3) @(negedge ref_clk_i);
		reset_i = 1'b0;
		repeat (6) @(negedge ref_clk_i);
		t_power_up();
		t_pulse_load();
		t_hold_load();
		t_pin_reset();
		t_second_end();
		end_sim();
	end
endmodule : octal_dac_serial_load_control_test
